// file: data_slicer.sv
module data_slicer #(
  parameter int DCLK_CYCLES = rxctl_pkg::DCLK_CYCLES,
  parameter int HOLD_CYCLES = rxctl_pkg::BLANK_HOLD_CYCLES
) (
  // clocking
  input wire logic clock,
  input wire logic arst_n,
  input wire logic clk_en,
  // control side
  slicer_if.filt   sl
);

  typedef struct packed {
    logic [15:0]                 div;
    logic [3:0]                  sub;
    logic [1:0]                  stable;
    logic                        level;
    logic [rxctl_pkg::CNT_W-1:0] blank;
    logic                        lost;
  } slicer_state_t;

  slicer_state_t state_ff;
  slicer_state_t nxt_state;
  logic          tick;
  logic          xtick;
  logic [3:0]    xdiv;

  if (DCLK_CYCLES < 1 || DCLK_CYCLES > 65535) begin : g_bad_dclk
    $error("data_slicer: DCLK_CYCLES out of range");
  end
  if (HOLD_CYCLES < 1 || HOLD_CYCLES >= (1 << rxctl_pkg::CNT_W)) begin : g_bad_hold
    $error("data_slicer: HOLD_CYCLES out of range");
  end

  // slower debounce tick for lower bands: 8, 4, 2, 1 base ticks
  assign xdiv  = 4'h8 >> sl.band;
  assign tick  = state_ff.div == 16'(DCLK_CYCLES - 1);
  assign xtick = tick && (state_ff.sub == xdiv - 4'h1);

  // debounce the demodulated bit and watch ask blanking time
  always_comb begin
    nxt_state = state_ff;
    if (!sl.enable || sl.restart) begin
      nxt_state = '0;
    end else begin
      nxt_state.div = tick ? 16'h0 : state_ff.div + 16'h1;
      if (tick) begin
        nxt_state.sub = xtick ? 4'h0 : state_ff.sub + 4'h1;
      end
      if (xtick) begin
        if (sl.sample != state_ff.level) begin
          if (state_ff.stable == 2'(rxctl_pkg::DEBOUNCE_TICKS - 1)) begin
            nxt_state.level  = sl.sample;
            nxt_state.stable = 2'h0;
          end else begin
            nxt_state.stable = state_ff.stable + 2'h1;
          end
        end else begin
          nxt_state.stable = 2'h0;
        end
      end
      // threshold is held through blanking up to the hold limit
      if (!sl.hold_en || state_ff.level) begin
        nxt_state.blank = '0;
        nxt_state.lost  = 1'b0;
      end else if (state_ff.blank == rxctl_pkg::CNT_W'(HOLD_CYCLES - 1)) begin
        nxt_state.lost = 1'b1;
      end else begin
        nxt_state.blank = state_ff.blank + 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= '0;
    end else if (clk_en) begin
      state_ff <= nxt_state;
    end
  end

  assign sl.sliced = state_ff.level;
  assign sl.lost   = state_ff.lost;

endmodule // data_slicer

// file: rf_front.sv
module rf_front (
  // clocking
  input wire logic       clock,
  input wire logic       arst_n,
  // scenario control
  input wire logic       ask,
  input wire logic       level,
  input wire logic       run,
  input wire logic [7:0] half,
  // front-end decisions
  output logic           carrier,
  output logic           upper
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_ff;
  logic       bit_ff;

  // preamble toggles every half cycles while run, else a steady level
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cnt_ff <= 8'h00;
      bit_ff <= 1'b0;
    end else if (run) begin
      cnt_ff <= (cnt_ff + 8'h01 >= half) ? 8'h00 : cnt_ff + 8'h01;
      if (cnt_ff + 8'h01 >= half) bit_ff <= ~bit_ff;
    end else begin
      bit_ff <= level;
    end
  end

  // unused decision line carries the inverse so a wrong select shows
  assign carrier = ask ? bit_ff : ~bit_ff;
  assign upper   = ask ? ~bit_ff : bit_ff;
endmodule // rf_front

// file: rx_mode_and_bitrate_control.sv
// Functional notes
// - both mode pins low: off, oscillator stopped, clock output off, input ignored.
// - enable only: standby, oscillator runs, clock output after oscillator start-up.
// - standby keeps receive path disabled and ignores transmitter signals.
// - enable and receive-activate high: active, received data forwarded on output.
// - active entry first runs PLL start-up: 261 us or 269 us by variant.
// - signal-processing start-up begins only after the PLL phase ends.
// - signal-processing start-up time depends on rate band and variant.
// - after both phases the receive path is declared ready.
// - FSK: upper deviation gives 1; ASK: carrier on gives 1.
// - two rate-select pins choose the data filter band.
// - band change in active mode settles within 100 us without restart (code: from ready or retune only; in signal start-up it reloads the start-up count).
// - band and modulation changed together: full start-up of the new band.
// - without RF during start-up, filter noise is passed to the output (code: data held low in the PLL phase and after a modulation change in ready or retune).
// - ASK blanking up to 52 ms keeps the data slicer behaviour.
// - modulation select high means ASK, low means FSK.
module rx_mode_and_bitrate_control #(
  parameter int PLL_433_CYCLES    = rxctl_pkg::PLL_433_CYCLES,
  parameter int PLL_315_CYCLES    = rxctl_pkg::PLL_315_CYCLES,
  parameter int SIG_433_CYCLES[4] = '{rxctl_pkg::SIG_433_R0_CYCLES, rxctl_pkg::SIG_433_R1_CYCLES,
                                      rxctl_pkg::SIG_433_R2_CYCLES, rxctl_pkg::SIG_433_R3_CYCLES},
  parameter int SIG_315_CYCLES[4] = '{rxctl_pkg::SIG_315_R0_CYCLES, rxctl_pkg::SIG_315_R1_CYCLES,
                                      rxctl_pkg::SIG_315_R2_CYCLES, rxctl_pkg::SIG_315_R3_CYCLES},
  parameter int RETUNE_CYCLES     = rxctl_pkg::RETUNE_CYCLES,
  parameter int BLANK_HOLD_CYCLES = rxctl_pkg::BLANK_HOLD_CYCLES,
  parameter int XTO_START_CYCLES  = rxctl_pkg::XTO_START_CYCLES,
  parameter int DCLK_CYCLES       = rxctl_pkg::DCLK_CYCLES
) (
  // clocking
  input  wire logic        clock,
  input  wire logic        arst_n,
  input  wire logic        clk_en,
  // mode pins from the host
  input  wire logic        rx_activate,
  input  wire logic        enable,
  input  wire logic        modulation_select,
  input  wire logic        rate_select_low,
  input  wire logic        rate_select_high,
  input  wire logic        clock_divider_sel0,
  input  wire logic        clock_divider_sel1,
  // front-end decisions
  input  wire logic        rf_input_carrier,
  input  wire logic        rf_input_upper,
  // outputs to the host
  output logic             data_out,
  output logic             clock_out_enable,
  output logic             osc_running,
  // avalon-mm slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest
);

  localparam int W = rxctl_pkg::CNT_W;

  typedef struct packed {
    rxctl_pkg::mode_t  mode;
    rxctl_pkg::phase_t phase;
    logic [W-1:0]      cnt;
    logic [W-1:0]      xto_cnt;
    logic              xto_ok;
    logic [1:0]        band;
    logic              mod_ask;
    logic              settle_low;
    logic              data;
    logic              clk_out_en;
    logic              ack;
    logic [31:0]       rdata;
    logic              variant_315;
    logic              hold_en;
  } ctrl_state_t;

  ctrl_state_t       state_ff;
  ctrl_state_t       nxt_state;
  rxctl_pkg::mode_t  mode_now;
  logic [1:0]        band_pin;
  logic              demod;
  logic              req;
  logic              path_on;
  slicer_if          sl ();

  // refuse counts that do not fit the counters
  if (PLL_433_CYCLES < 1 || PLL_433_CYCLES >= (1 << W)
      || PLL_315_CYCLES < 1 || PLL_315_CYCLES >= (1 << W)) begin : g_bad_pll
    $error("rx_mode_and_bitrate_control: PLL count out of range");
  end
  for (genvar i = 0; i < 4; i++) begin : g_chk_sig
    if (SIG_433_CYCLES[i] < 1 || SIG_433_CYCLES[i] >= (1 << W)
        || SIG_315_CYCLES[i] < 1 || SIG_315_CYCLES[i] >= (1 << W)) begin : g_bad_sig
      $error("rx_mode_and_bitrate_control: start-up count out of range");
    end
  end
  if (RETUNE_CYCLES < 1 || RETUNE_CYCLES >= (1 << W)
      || XTO_START_CYCLES < 1 || XTO_START_CYCLES >= (1 << W)) begin : g_bad_misc
    $error("rx_mode_and_bitrate_control: retune or oscillator count out of range");
  end

  // signal-processing start-up reload value for a band and variant
  function automatic logic [W-1:0] sig_load(input logic v315, input logic [1:0] b);
    int c;
    c = v315 ? SIG_315_CYCLES[b] : SIG_433_CYCLES[b];
    return W'(c - 1);
  endfunction

  // pll start-up reload value for a variant
  function automatic logic [W-1:0] pll_load(input logic v315);
    return v315 ? W'(PLL_315_CYCLES - 1) : W'(PLL_433_CYCLES - 1);
  endfunction

  // operating mode decoded from the two mode pins
  always_comb begin
    if (!enable) begin
      mode_now = rxctl_pkg::MODE_OFF;
    end else if (!rx_activate) begin
      mode_now = rxctl_pkg::MODE_STANDBY;
    end else begin
      mode_now = rxctl_pkg::MODE_ACTIVE;
    end
  end

  // band and demodulated bit from the host and front-end pins
  assign band_pin = {rate_select_high, rate_select_low};
  assign demod    = modulation_select ? rf_input_carrier : rf_input_upper;
  assign req      = avs_read || avs_write;

  // filter drive: runs only once the pll phase is over
  assign path_on    = (state_ff.phase == rxctl_pkg::PH_SIG)
                      || (state_ff.phase == rxctl_pkg::PH_READY)
                      || (state_ff.phase == rxctl_pkg::PH_RETUNE);
  assign sl.sample  = demod;
  assign sl.enable  = path_on;
  assign sl.restart = (state_ff.phase == rxctl_pkg::PH_PLL);
  assign sl.band    = state_ff.band;
  assign sl.hold_en = state_ff.hold_en && state_ff.mod_ask;

  data_slicer #(
    .DCLK_CYCLES (DCLK_CYCLES),
    .HOLD_CYCLES (BLANK_HOLD_CYCLES)
  ) u_slicer (
    .clock  (clock),
    .arst_n (arst_n),
    .clk_en (clk_en),
    .sl     (sl)
  );

  // next-state logic: oscillator, start-up sequence, output, bus
  always_comb begin
    nxt_state      = state_ff;
    nxt_state.mode = mode_now;

    // oscillator start-up, stopped in off mode
    if (mode_now == rxctl_pkg::MODE_OFF) begin
      nxt_state.xto_cnt = '0;
      nxt_state.xto_ok  = 1'b0;
    end else if (!state_ff.xto_ok) begin
      if (state_ff.xto_cnt == W'(XTO_START_CYCLES - 1)) begin
        nxt_state.xto_ok = 1'b1;
      end else begin
        nxt_state.xto_cnt = state_ff.xto_cnt + 1'b1;
      end
    end
    nxt_state.clk_out_en = nxt_state.xto_ok
                           && (clock_divider_sel0 || clock_divider_sel1);

    // receive start-up sequence
    if (mode_now != rxctl_pkg::MODE_ACTIVE) begin
      nxt_state.phase      = rxctl_pkg::PH_IDLE;
      nxt_state.cnt        = '0;
      nxt_state.settle_low = 1'b0;
    end else begin
      case (state_ff.phase)
        rxctl_pkg::PH_IDLE: begin
          if (state_ff.xto_ok) begin
            nxt_state.phase = rxctl_pkg::PH_PLL;
            nxt_state.cnt   = pll_load(state_ff.variant_315);
          end
        end
        rxctl_pkg::PH_PLL: begin
          if (state_ff.cnt == '0) begin
            nxt_state.phase      = rxctl_pkg::PH_SIG;
            nxt_state.band       = band_pin;
            nxt_state.mod_ask    = modulation_select;
            nxt_state.settle_low = 1'b0;
            nxt_state.cnt        = sig_load(state_ff.variant_315, band_pin);
          end else begin
            nxt_state.cnt = state_ff.cnt - 1'b1;
          end
        end
        rxctl_pkg::PH_SIG: begin
          if (band_pin != state_ff.band || modulation_select != state_ff.mod_ask) begin
            nxt_state.band    = band_pin;
            nxt_state.mod_ask = modulation_select;
            nxt_state.cnt     = sig_load(state_ff.variant_315, band_pin);
          end else if (state_ff.cnt == '0) begin
            nxt_state.phase      = rxctl_pkg::PH_READY;
            nxt_state.settle_low = 1'b0;
          end else begin
            nxt_state.cnt = state_ff.cnt - 1'b1;
          end
        end
        rxctl_pkg::PH_READY, rxctl_pkg::PH_RETUNE: begin
          if (modulation_select != state_ff.mod_ask) begin
            nxt_state.phase      = rxctl_pkg::PH_SIG;
            nxt_state.band       = band_pin;
            nxt_state.mod_ask    = modulation_select;
            nxt_state.settle_low = 1'b1;
            nxt_state.cnt        = sig_load(state_ff.variant_315, band_pin);
          end else if (band_pin != state_ff.band) begin
            nxt_state.phase = rxctl_pkg::PH_RETUNE;
            nxt_state.band  = band_pin;
            nxt_state.cnt   = W'(RETUNE_CYCLES - 1);
          end else if (state_ff.phase == rxctl_pkg::PH_RETUNE) begin
            if (state_ff.cnt == '0) begin
              nxt_state.phase = rxctl_pkg::PH_READY;
            end else begin
              nxt_state.cnt = state_ff.cnt - 1'b1;
            end
          end
        end
        default: begin
          nxt_state.phase = rxctl_pkg::PH_IDLE;
          nxt_state.cnt   = '0;
        end
      endcase
    end

    // data output: low outside the receive path and while a modulation change made after ready settles
    if (mode_now != rxctl_pkg::MODE_ACTIVE || !path_on) begin
      nxt_state.data = 1'b0;
    end else if (state_ff.phase == rxctl_pkg::PH_SIG && state_ff.settle_low) begin
      nxt_state.data = 1'b0;
    end else begin
      nxt_state.data = sl.sliced;
    end

    // bus: one wait cycle, then the access completes
    nxt_state.ack = req && !state_ff.ack;
    if (req && !state_ff.ack) begin
      nxt_state.rdata = 32'h0;
      if (avs_read) begin
        case (avs_address)
          rxctl_pkg::CTRL_OFS: begin
            nxt_state.rdata[rxctl_pkg::CTRL_VARIANT_BIT] = state_ff.variant_315;
            nxt_state.rdata[rxctl_pkg::CTRL_HOLD_BIT]    = state_ff.hold_en;
          end
          rxctl_pkg::STATUS_OFS: begin
            nxt_state.rdata[rxctl_pkg::ST_MODE_LSB +: 2]  = state_ff.mode;
            nxt_state.rdata[rxctl_pkg::ST_PHASE_LSB +: 3] = state_ff.phase;
            nxt_state.rdata[rxctl_pkg::ST_XTO_BIT]        = state_ff.xto_ok;
            nxt_state.rdata[rxctl_pkg::ST_READY_BIT]      =
              (state_ff.phase == rxctl_pkg::PH_READY);
            nxt_state.rdata[rxctl_pkg::ST_LOST_BIT]       = sl.lost;
            nxt_state.rdata[rxctl_pkg::ST_BAND_LSB +: 2]  = state_ff.band;
            nxt_state.rdata[rxctl_pkg::ST_ASK_BIT]        = state_ff.mod_ask;
          end
          rxctl_pkg::COUNT_OFS: begin
            nxt_state.rdata[W-1:0] = state_ff.cnt;
          end
          default: begin
            nxt_state.rdata = 32'h0;
          end
        endcase
      end
    end
    if (avs_write && state_ff.ack && avs_address == rxctl_pkg::CTRL_OFS
        && avs_byteenable[0]) begin
      nxt_state.variant_315 = avs_writedata[rxctl_pkg::CTRL_VARIANT_BIT];
      nxt_state.hold_en     = avs_writedata[rxctl_pkg::CTRL_HOLD_BIT];
    end
  end

  // state register
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_ff             <= '0;
      state_ff.mode        <= rxctl_pkg::MODE_OFF;
      state_ff.phase       <= rxctl_pkg::PH_IDLE;
      state_ff.variant_315 <= rxctl_pkg::CTRL_VARIANT_RST;
      state_ff.hold_en     <= rxctl_pkg::CTRL_HOLD_RST;
    end else if (clk_en) begin
      state_ff <= nxt_state;
    end
  end

  // outputs
  assign data_out         = state_ff.data;
  assign clock_out_enable = state_ff.clk_out_en;
  assign osc_running      = state_ff.xto_ok;
  assign avs_readdata     = state_ff.rdata;
  assign avs_waitrequest  = req && (!state_ff.ack || !clk_en); // frozen state keeps the bus waiting

endmodule // rx_mode_and_bitrate_control

// file: rx_mode_and_bitrate_control_tb.sv
module rx_mode_and_bitrate_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // short local names for package constants
  localparam rxctl_pkg::mode_t M_OFF = rxctl_pkg::MODE_OFF;
  localparam rxctl_pkg::mode_t M_SBY = rxctl_pkg::MODE_STANDBY;
  localparam rxctl_pkg::mode_t M_ACT = rxctl_pkg::MODE_ACTIVE;
  localparam rxctl_pkg::phase_t P_IDLE = rxctl_pkg::PH_IDLE;
  localparam rxctl_pkg::phase_t P_PLL = rxctl_pkg::PH_PLL;
  localparam rxctl_pkg::phase_t P_SIG = rxctl_pkg::PH_SIG;
  localparam rxctl_pkg::phase_t P_RDY = rxctl_pkg::PH_READY;
  localparam rxctl_pkg::phase_t P_RTN = rxctl_pkg::PH_RETUNE;
  localparam logic [3:0] A_STAT = rxctl_pkg::STATUS_OFS;
  localparam int PLL4 = 20;
  localparam int PLL3 = 24;
  localparam int SIG4[4] = '{60, 50, 40, 30};
  localparam int SIG3[4] = '{64, 54, 44, 34};
  localparam int RT = 10;
  localparam int BH = 50;
  localparam logic [31:0] MSK = 32'h0000077f;
  localparam logic [31:0] MSK_NR = 32'h0000073f;
  typedef struct {logic [31:0] e; logic [31:0] m;} note_t;
  logic clock, arst_n, clk_en, rx_activate, enable, modulation_select;
  logic rate_select_low, rate_select_high, clock_divider_sel0, clock_divider_sel1;
  logic carrier, upper, data_out, clock_out_enable, osc_running, run, level;
  logic [7:0] half;
  logic [3:0] avs_address, avs_byteenable;
  logic avs_read, avs_write, avs_waitrequest;
  logic [31:0] avs_writedata, avs_readdata, seed;
  int errors, total_checks, now, base, p, s;
  note_t notes[$];
  note_t n;

  rx_mode_and_bitrate_control #(.PLL_433_CYCLES(PLL4), .PLL_315_CYCLES(PLL3),
    .SIG_433_CYCLES(SIG4), .SIG_315_CYCLES(SIG3), .RETUNE_CYCLES(RT),
    .BLANK_HOLD_CYCLES(BH), .XTO_START_CYCLES(5), .DCLK_CYCLES(2)) dut_u (.clock(clock),
    .arst_n(arst_n), .clk_en(clk_en), .rx_activate(rx_activate), .enable(enable),
    .modulation_select(modulation_select), .rate_select_low(rate_select_low),
    .rate_select_high(rate_select_high), .clock_divider_sel0(clock_divider_sel0),
    .clock_divider_sel1(clock_divider_sel1), .rf_input_carrier(carrier),
    .rf_input_upper(upper), .data_out(data_out), .clock_out_enable(clock_out_enable),
    .osc_running(osc_running), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

  rf_front rf_u (.clock(clock), .arst_n(arst_n), .ask(modulation_select), .level(level),
    .run(run), .half(half), .carrier(carrier), .upper(upper));

  // clock and cycle count
  always #10 clock = ~clock;
  always @(posedge clock) now <= now + 1;

  // completed reads are compared against the oldest note
  always @(posedge clock) begin
    if (avs_read && avs_waitrequest === 1'b0 && notes.size() > 0) begin
      n = notes.pop_front();
      check(avs_readdata & n.m, n.e);
    end
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [31:0] st(input rxctl_pkg::mode_t md, input rxctl_pkg::phase_t ph,
                                     input logic [1:0] bd, input logic ask);
    st = 32'h0;
    st[rxctl_pkg::ST_MODE_LSB +: 2] = md;
    st[rxctl_pkg::ST_PHASE_LSB +: 3] = ph;
    st[rxctl_pkg::ST_XTO_BIT] = (md != M_OFF);
    st[rxctl_pkg::ST_READY_BIT] = (ph == P_RDY);
    st[rxctl_pkg::ST_BAND_LSB +: 2] = bd;
    st[rxctl_pkg::ST_ASK_BIT] = ask;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one avalon access, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= ~w;
    avs_write <= w;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clock);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    notes.push_back('{e, m});
    bus(1'b0, a, 32'h0);
  endtask

  task automatic at(input int c);
    while (now < base + c) @(posedge clock);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // watchdog
  initial begin
    #(20 * 20000);
    errors++;
    print_verdict();
  end

  // main sequence
  initial begin
    {clock, arst_n, rx_activate, enable, modulation_select, avs_read, avs_write} = '0;
    {rate_select_low, rate_select_high, clock_divider_sel0, clock_divider_sel1} = '0;
    {avs_address, avs_writedata, now, base, errors, total_checks} = '0;
    {clk_en, run, level, avs_byteenable, half, seed} = {3'h6, 4'hf, 8'h08, 32'd34388};
    repeat (20) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    rd(rxctl_pkg::CTRL_OFS, 32'h3, 32'h2);
    bus(1'b1, 4'hc, xs());
    rd(4'hc, 32'hffffffff, 32'h0);
    rd(A_STAT, MSK, st(M_OFF, P_IDLE, 2'h0, 1'b0));
    {clk_en, enable} <= 2'h1;
    repeat (12) @(posedge clock);
    check(osc_running, 1'b0);
    clk_en <= 1'b1;
    repeat (12) @(posedge clock);
    check(osc_running, 1'b1);
    check(clock_out_enable, 1'b0);
    {clock_divider_sel1, clock_divider_sel0} <= xs() % 3 + 1;
    repeat (3) @(posedge clock);
    check(clock_out_enable, 1'b1);
    rd(A_STAT, MSK, st(M_SBY, P_IDLE, 2'h0, 1'b0));
    $display("test modes done");
    for (int v = 0; v < 2; v++) begin
      for (int b = 0; b < 4; b++) begin
        rx_activate <= 1'b0;
        {rate_select_high, rate_select_low} <= b[1:0];
        bus(1'b1, rxctl_pkg::CTRL_OFS, {30'h0, 1'b1, v[0]});
        half <= 8'h08 + {5'h0, 3'(xs())};
        rx_activate <= 1'b1;
        base = now;
        p = v ? PLL3 : PLL4;
        s = v ? SIG3[b] : SIG4[b];
        at(3);
        // band field still shows the band latched at the previous pll end
        rd(A_STAT, MSK, st(M_ACT, P_PLL, (v + b == 0) ? 2'h0 : 2'(b + 3), 1'b0));
        at(p + 5);
        rd(A_STAT, MSK, st(M_ACT, P_SIG, b[1:0], 1'b0));
        at(p + s - 4);
        rd(A_STAT, MSK, st(M_ACT, P_SIG, b[1:0], 1'b0));
        at(p + s + 6);
        rd(A_STAT, MSK, st(M_ACT, P_RDY, b[1:0], 1'b0));
      end
    end
    $display("test start-up done");
    run <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      modulation_select <= !k[1];
      level <= !k[0];
      repeat (SIG3[3] + 40) @(posedge clock);
      check(data_out, !k[0]);
    end
    $display("test demodulation done");
    {rate_select_high, rate_select_low} <= 2'h2;
    base = now;
    at(2);
    rd(A_STAT, MSK_NR, st(M_ACT, P_RTN, 2'h2, 1'b0));
    at(RT + 6);
    rd(A_STAT, MSK, st(M_ACT, P_RDY, 2'h2, 1'b0));
    {rate_select_high, rate_select_low, modulation_select, level} <= 4'h3;
    base = now;
    at(3);
    rd(A_STAT, MSK, st(M_ACT, P_SIG, 2'h0, 1'b1));
    at(SIG3[0] - 4);
    rd(A_STAT, MSK, st(M_ACT, P_SIG, 2'h0, 1'b1));
    at(SIG3[0] + 50);
    rd(A_STAT, MSK, st(M_ACT, P_RDY, 2'h0, 1'b1));
    level <= 1'b0;
    base = now;
    at(25);
    rd(A_STAT, 32'h1 << rxctl_pkg::ST_LOST_BIT, 32'h0);
    at(BH + 60);
    rd(A_STAT, 32'h1 << rxctl_pkg::ST_LOST_BIT, 32'h1 << rxctl_pkg::ST_LOST_BIT);
    $display("test retune and blanking done");
    {enable, rx_activate} <= 2'h0;
    repeat (4) @(posedge clock);
    check(osc_running, 1'b0);
    check(clock_out_enable, 1'b0);
    check(data_out, 1'b0);
    rd(A_STAT, MSK, st(M_OFF, P_IDLE, 2'h0, 1'b1));
    $display("test off done");
    print_verdict();
  end
endmodule // rx_mode_and_bitrate_control_tb

bind rx_mode_and_bitrate_control rxctl_assertions chk_u (.clock(clock), .arst_n(arst_n),
  .clk_en(clk_en),
  .rx_activate(rx_activate), .enable(enable), .modulation_select(modulation_select),
  .clock_divider_sel0(clock_divider_sel0), .clock_divider_sel1(clock_divider_sel1),
  .data_out(data_out), .clock_out_enable(clock_out_enable), .osc_running(osc_running),
  .avs_read(avs_read), .avs_waitrequest(avs_waitrequest));

// file: rxctl_assertions.sv
module rxctl_assertions (
  // clocking
  input wire logic clock,
  input wire logic arst_n,
  input wire logic clk_en,
  // mode pins
  input wire logic rx_activate,
  input wire logic enable,
  input wire logic modulation_select,
  input wire logic clock_divider_sel0,
  input wire logic clock_divider_sel1,
  // outputs
  input wire logic data_out,
  input wire logic clock_out_enable,
  input wire logic osc_running,
  // bus
  input wire logic avs_read,
  input wire logic avs_waitrequest
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);

  // off held, clock output deselected, entry into active
  sequence off_held;
    !enable [*2];
  endsequence
  sequence sel_off;
    (!clock_divider_sel0 && !clock_divider_sel1) [*2];
  endsequence
  sequence act_entry;
    $rose(rx_activate && enable && osc_running);
  endsequence

  a_off_osc_stop: assert property (!enable |=> !osc_running)
    else $error("oscillator running in off mode");
  a_off_clock_idle: assert property (off_held |=> !clock_out_enable)
    else $error("clock output in off mode");
  a_sel_clock_off: assert property (sel_off |=> !clock_out_enable)
    else $error("clock output while deselected");
  a_osc_start_wait: assert property ($rose(enable) |-> !osc_running [*3])
    else $error("oscillator ok too early");
  a_osc_start_done: assert property ((enable && clk_en) [*8] |-> osc_running)
    else $error("oscillator ok too late");
  a_idle_data_low: assert property ((!rx_activate) [*2] |-> !data_out)
    else $error("data out of active mode");
  a_pll_data_low: assert property (act_entry |-> !data_out [*8])
    else $error("data during pll start");
  a_mod_data_low: assert property ($changed(modulation_select) && rx_activate && enable
    |-> ##2 !data_out [*8])
    else $error("data after modulation change");
  a_bus_one_wait: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("read wait not one cycle");
endmodule // rxctl_assertions

// file: rxctl_pkg.sv
package rxctl_pkg;

  // system clock
  localparam int CLOCK_MHZ = 50;

  // start-up and retune times in microseconds, blanking hold in milliseconds
  localparam int PLL_433_US = 261;
  localparam int PLL_315_US = 269;
  localparam int SIG_433_R0_US = 1096;
  localparam int SIG_433_R1_US = 644;
  localparam int SIG_433_R2_US = 417;
  localparam int SIG_433_R3_US = 304;
  localparam int SIG_315_R0_US = 1132;
  localparam int SIG_315_R1_US = 665;
  localparam int SIG_315_R2_US = 431;
  localparam int SIG_315_R3_US = 324;
  localparam int RETUNE_US = 100;
  localparam int BLANK_HOLD_MS = 52;

  // derived cycle counts (exact at 50 MHz)
  localparam int PLL_433_CYCLES = PLL_433_US * CLOCK_MHZ;
  localparam int PLL_315_CYCLES = PLL_315_US * CLOCK_MHZ;
  localparam int SIG_433_R0_CYCLES = SIG_433_R0_US * CLOCK_MHZ;
  localparam int SIG_433_R1_CYCLES = SIG_433_R1_US * CLOCK_MHZ;
  localparam int SIG_433_R2_CYCLES = SIG_433_R2_US * CLOCK_MHZ;
  localparam int SIG_433_R3_CYCLES = SIG_433_R3_US * CLOCK_MHZ;
  localparam int SIG_315_R0_CYCLES = SIG_315_R0_US * CLOCK_MHZ;
  localparam int SIG_315_R1_CYCLES = SIG_315_R1_US * CLOCK_MHZ;
  localparam int SIG_315_R2_CYCLES = SIG_315_R2_US * CLOCK_MHZ;
  localparam int SIG_315_R3_CYCLES = SIG_315_R3_US * CLOCK_MHZ;
  localparam int RETUNE_CYCLES = RETUNE_US * CLOCK_MHZ;
  localparam int BLANK_HOLD_CYCLES = BLANK_HOLD_MS * 1000 * CLOCK_MHZ;

  // oscillator start-up and slicer base tick, plain defaults
  localparam int XTO_START_CYCLES = 100;
  localparam int DCLK_CYCLES = 59;
  localparam int DEBOUNCE_TICKS = 2;
  localparam int CNT_W = 24;

  // register byte offsets
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STATUS_OFS = 4'h4;
  localparam logic [3:0] COUNT_OFS = 4'h8;

  // control fields and reset values
  localparam int CTRL_VARIANT_BIT = 0;
  localparam int CTRL_HOLD_BIT = 1;
  localparam logic CTRL_VARIANT_RST = 1'h0;
  localparam logic CTRL_HOLD_RST = 1'h1;

  // status fields
  localparam int ST_MODE_LSB = 0;
  localparam int ST_PHASE_LSB = 2;
  localparam int ST_XTO_BIT = 5;
  localparam int ST_READY_BIT = 6;
  localparam int ST_LOST_BIT = 7;
  localparam int ST_BAND_LSB = 8;
  localparam int ST_ASK_BIT = 10;

  typedef enum logic [1:0] {MODE_OFF, MODE_STANDBY, MODE_ACTIVE} mode_t;
  typedef enum logic [2:0] {PH_IDLE, PH_PLL, PH_SIG, PH_READY, PH_RETUNE} phase_t;

endpackage

// file: slicer_if.sv
interface slicer_if;
  logic       sample;
  logic       enable;
  logic       restart;
  logic       hold_en;
  logic [1:0] band;
  logic       sliced;
  logic       lost;

  modport ctrl (output sample, enable, restart, hold_en, band, input sliced, lost);
  modport filt (input sample, enable, restart, hold_en, band, output sliced, lost);
endinterface
